//--- bench/bcc_charger_control_tb.sv
// Self-checking bench for the charger control block.
// Assumes the checker is bound in by its own file and the host model drives the register port.
`timescale 1ns/1ps
module bcc_charger_control_tb;
  import bcc_pkg::*;
  localparam int WC = 100;
  typedef struct packed {
    logic [7:0] a;
    logic w;
    logic [7:0] d;
    logic c;
    logic [7:0] rd;
    logic v, sw, ax, lv;
  } bcc_row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sup, ths, inz, bbp, dcur, ilim, tmr, suv, sdp, cdp, cc1, vcn, wr, sus, fin_n, valid;
  logic ovr, swo, dsw, aux, lvl, done;
  logic [1:0] zone, conv;
  logic [2:0] phase, pcur;
  logic [7:0] addr, wdata, rdata, pthr, ilim_o;
  int fail_count = 0;
  int n_tests = 0;
  bcc_row_s rows [10] = '{
    '{8'h35, 1'b0, 8'h00, 1'b0, 8'h01, 1'b1, 1'b0, 1'b0, 1'b0},
    '{8'h41, 1'b0, 8'h00, 1'b0, 8'h01, 1'b1, 1'b0, 1'b0, 1'b0},
    '{8'h1d, 1'b0, 8'h00, 1'b0, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0},
    '{8'h1e, 1'b1, 8'ha5, 1'b0, 8'ha5, 1'b1, 1'b0, 1'b0, 1'b0},
    '{8'h50, 1'b1, 8'hff, 1'b0, 8'h00, 1'b0, 1'b0, 1'b0, 1'b0},
    '{8'h2f, 1'b1, 8'h05, 1'b0, 8'h05, 1'b1, 1'b1, 1'b1, 1'b0},
    '{8'h2f, 1'b1, 8'h0a, 1'b0, 8'h0a, 1'b1, 1'b0, 1'b0, 1'b0},
    '{8'h2f, 1'b1, 8'h1a, 1'b1, 8'h1a, 1'b1, 1'b1, 1'b1, 1'b1},
    '{8'h2f, 1'b1, 8'h00, 1'b1, 8'h00, 1'b1, 1'b0, 1'b0, 1'b0},
    '{8'h40, 1'b1, 8'hff, 1'b0, 8'h10, 1'b1, 1'b0, 1'b0, 1'b0}};
  // ==========================================================================
  // Clock, design and host
  // Free-running 100 MHz clock.
  always #5 clk = ~clk;
  bcc_charger_control #(.WEAK_CYCLES(WC)) u_dut (.mclk_i(clk), .rst_i(rst), .reg_wr_i(wr),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_valid_o(valid),
    .input_supply_i(sup), .force_suspend_in_i(sus), .fault_in_n_i(fin_n),
    .thermistor_sense_high_i(ths), .temp_zone_i(zone), .temp_in_zone_i(inz),
    .bat_below_precharge_i(bbp), .done_current_i(dcur), .ilim_active_i(ilim),
    .timer_expired_i(tmr), .sys_above_uv_i(suv), .sdp_detected_i(sdp), .cdp_detected_i(cdp),
    .cc1_active_i(cc1), .vconn_needed_i(vcn), .phase_o(phase), .conv_mode_o(conv),
    .precharge_current_o(pcur), .fast_current_mod_o(), .precharge_threshold_o(pthr),
    .voltage_reduce_o(), .charge_done_o(done), .thermistor_pullup_o(), .input_ilim_o(ilim_o),
    .ilim_override_o(ovr), .input_switch_open_o(swo), .data_switch_on_o(dsw),
    .aux_regulator_out_o(aux), .aux_regulator_level_o(lvl), .orientation_out_o(),
    .orientation_out_oe_o(), .system_ok_out_o(), .system_ok_out_oe_o(),
    .conn_supply_enable_o());
  bcc_host_model u_host (.mclk_i(clk), .reg_wr_o(wr), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .force_suspend_o(sus), .fault_in_n_o(fin_n));
  // ==========================================================================
  // Helpers
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic wrap_up;
    if (fail_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Holds reset for three cycles, checking once, before release, that the switch is open.
  task automatic do_reset;
    @(negedge clk);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    chk("switch_in_reset", 8'h01, 8'(swo));
    rst = 1'b0;
  endtask
  // ==========================================================================
  // Stimulus
  // Table rows first, then the hand-written sequences.
  initial begin
    {ths, bbp, dcur, ilim, tmr, sdp, cdp, cc1, vcn} = '0;
    {sup, suv, inz} = 3'b111;
    zone = 2'h1;
    do_reset();
    for (int i = 0; i < 10; i++) begin
      cdp = rows[i].c;
      if (rows[i].w) u_host.wr(rows[i].a, rows[i].d);
      u_host.rd(rows[i].a);
      chk("rdata", rows[i].rd, rdata);
      chk("valid", 8'(rows[i].v), 8'(valid));
      @(negedge clk);
      chk("data_switch", 8'(rows[i].sw), 8'(dsw));
      chk("aux_out", 8'(rows[i].ax), 8'(aux));
      chk("aux_level", 8'(rows[i].lv), 8'(lvl));
    end
    chk("threshold", 8'ha5, pthr);
    u_host.pins(1'b1, 1'b1);
    repeat (5) @(negedge clk);
    chk("suspend_switch", 8'h01, 8'(swo));
    chk("suspend_ilim", 8'h00, ilim_o);
    u_host.wr(8'h35, 8'h03);
    repeat (5) @(negedge clk);
    chk("masked_switch", 8'h00, 8'(swo));
    u_host.wr(8'h35, 8'h01);
    u_host.pins(1'b0, 1'b1);
    suv = 1'b0;
    repeat (3) @(negedge clk);
    chk("uv_switch", 8'h01, 8'(swo));
    suv = 1'b1;
    bbp = 1'b1;
    u_host.wr(8'h1d, 8'h01);
    repeat (4) @(negedge clk);
    chk("phase_pre", 8'(BCC_PRE), 8'(phase));
    chk("conv_pre", 8'(BCC_CONV_VSRC), 8'(conv));
    u_host.pins(1'b0, 1'b0);
    repeat (5) @(negedge clk);
    chk("phase_fault", 8'(BCC_FAULT), 8'(phase));
    u_host.pins(1'b0, 1'b1);
    repeat (5) @(negedge clk);
    chk("phase_release", 8'(BCC_PRE), 8'(phase));
    tmr = 1'b1;
    @(negedge clk);
    tmr = 1'b0;
    repeat (5) @(negedge clk);
    u_host.rd(8'h40);
    chk("fault_latched", 8'h40, rdata & 8'h40);
    u_host.recover(1);
    u_host.rd(8'h40);
    chk("fault_cleared", 8'h00, rdata & 8'h40);
    sdp = 1'b1;
    repeat (4) @(negedge clk);
    chk("weak_ilim", 8'h04, ilim_o);
    chk("weak_owner", 8'h01, 8'(ovr));
    repeat (WC + 5) @(negedge clk);
    chk("weak_expired", 8'h00, ilim_o);
    do_reset();
    repeat (10) @(negedge clk);
    u_host.wr(8'h41, 8'h00);
    repeat (3) @(negedge clk);
    chk("weak_release", 8'h00, 8'(ovr));
    {bbp, sdp, dcur, ilim} = 4'b0011;
    u_host.wr(8'h1d, 8'h0f);
    repeat (6) @(negedge clk);
    chk("phase_term", 8'(BCC_TERM), 8'(phase));
    chk("pre_current", 8'h07, 8'(pcur));
    repeat (14010) @(negedge clk);
    chk("done_ilim", 8'h00, 8'(done));
    ilim = 1'b0;
    repeat (13990) @(negedge clk);
    chk("done_early", 8'h00, 8'(done));
    repeat (20) @(negedge clk);
    chk("done_late", 8'h01, 8'(done));
    {cc1, vcn, inz} = 3'b110;
    u_host.wr(8'h1c, 8'h01);
    repeat (5) @(negedge clk);
    chk("thermal_off", 8'(BCC_IDLE), 8'(phase));
    ths = 1'b1;
    repeat (3) @(negedge clk);
    u_host.rd(8'h40);
    chk("battery_absent", 8'h00, rdata & 8'h10);
    chk("orient_status", 8'h80, rdata & 8'h80);
    wrap_up();
  end
  // Cuts a hang short well beyond the expected run length.
  initial begin
    #500000;
    fail_count++;
    wrap_up();
  end
endmodule

//--- bench/bcc_checker_properties.sv
// Concurrent checks on the charger control ports.
// Assumes a bind onto bcc_charger_control, one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module bcc_checker
  import bcc_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic input_supply_i,
  input wire logic done_current_i,
  input wire logic ilim_active_i,
  input wire logic sys_above_uv_i,
  input wire logic cc1_active_i,
  input wire logic vconn_needed_i,
  input wire logic [2:0] phase_o,
  input wire logic [1:0] conv_mode_o,
  input wire logic charge_done_o,
  input wire logic input_switch_open_o,
  input wire logic orientation_out_o,
  input wire logic orientation_out_oe_o,
  input wire logic system_ok_out_oe_o,
  input wire logic conn_supply_enable_o
);
  // ==========================================================================
  // Helper logic
  // Counts cycles in which the raw done condition holds with no input limiting.
  logic [15:0] run_q;
  always_ff @(posedge mclk_i) begin
    if (rst_i || !done_current_i || ilim_active_i) begin
      run_q <= 16'h0000;
    end else if (run_q != 16'hffff) begin
      run_q <= run_q + 16'h0001;
    end
  end
  // ==========================================================================
  // Properties
  // Every check samples on the main clock and stays quiet during reset.
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  a_conv_vsrc_mode: assert property (
    phase_o inside {BCC_PRE, BCC_TERM} && $stable(phase_o) |-> conv_mode_o == BCC_CONV_VSRC)
    else $error("Converter is not a voltage source in precharge or termination.");
  a_conv_isrc_mode: assert property (
    phase_o == BCC_FAST && $stable(phase_o) |-> conv_mode_o == BCC_CONV_ISRC)
    else $error("Converter is not a current source in fast charge.");
  a_done_no_ilim: assert property (
    ilim_active_i [*3] |=> !$rose(charge_done_o))
    else $error("Charge done raised while input limit was active.");
  a_done_debounce_len: assert property (
    $rose(charge_done_o) |-> $past(run_q, 3) >= 16'd13999)
    else $error("Charge done raised before the debounce interval.");
  a_orient_pull_low: assert property (
    input_supply_i && $past(input_supply_i) && !$past(rst_i)
      |-> orientation_out_oe_o == $past(cc1_active_i) && !orientation_out_o)
    else $error("Orientation output does not follow the active channel.");
  a_system_ok_out_follow_rail: assert property (
    input_supply_i && $past(input_supply_i) && !$past(rst_i)
      |-> system_ok_out_oe_o == $past(sys_above_uv_i))
    else $error("System OK output does not follow the rail comparator.");
  a_uv_open_switch: assert property (
    $past(input_supply_i && !sys_above_uv_i) && !$past(rst_i) |-> input_switch_open_o)
    else $error("Input switch stayed closed with the rail undervoltage.");
  a_conn_supply_enable: assert property (
    input_supply_i && $past(input_supply_i) && !$past(rst_i)
      |-> conn_supply_enable_o == $past(vconn_needed_i))
    else $error("Connector supply enable does not follow the cable need.");
endmodule

bind bcc_charger_control bcc_checker u_chk (.mclk_i, .rst_i, .input_supply_i, .done_current_i,
  .ilim_active_i, .sys_above_uv_i, .cc1_active_i, .vconn_needed_i, .phase_o, .conv_mode_o,
  .charge_done_o, .input_switch_open_o, .orientation_out_o, .orientation_out_oe_o,
  .system_ok_out_oe_o, .conn_supply_enable_o);

//--- bench/bcc_host_model.sv
// Host controller model: register writes and reads, suspend and fault pins.
// Assumes the register port samples on the rising edge; everything here moves on the falling one.
`timescale 1ns/1ps
module bcc_host_model #(
  parameter int ON_CYC = 60,
  parameter int OFF_CYC = 1
) (
  input wire logic mclk_i,
  output logic reg_wr_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  output logic force_suspend_o,
  output logic fault_in_n_o
);
  // ==========================================================================
  // Idle state
  // Starts released: no write, no suspend, fault pin high.
  initial begin
    reg_wr_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    force_suspend_o = 1'b0;
    fault_in_n_o = 1'b1;
  end
  // ==========================================================================
  // Bus and pin tasks
  // Holds strobe, address and data across exactly one rising edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    reg_addr_o = a;
    reg_wdata_o = d;
    reg_wr_o = 1'b1;
    @(negedge mclk_i);
    reg_wr_o = 1'b0;
  endtask
  // Read data is valid one cycle after the address settles.
  task automatic rd(input logic [7:0] a);
    @(negedge mclk_i);
    reg_addr_o = a;
    @(negedge mclk_i);
  endtask
  // Drives the suspend pin and the active-low fault pin.
  task automatic pins(input logic sus, input logic flt_n);
    @(negedge mclk_i);
    force_suspend_o = sus;
    fault_in_n_o = flt_n;
  endtask
  // Recovery pulses on charge enable, time-scaled; the falling write also clears latches.
  task automatic recover(input int n);
    repeat (n) begin
      wr(8'h1d, 8'h01);
      repeat (ON_CYC) @(negedge mclk_i);
      wr(8'h1d, 8'h00);
      repeat (OFF_CYC) @(negedge mclk_i);
    end
  endtask
endmodule

//--- hdl/bcc_charger_control.sv
// Charger control: phase sequencing, done debounce, thermal zones, weak battery, pins.
// Assumes a register write/read port from an external serial slave and analog comparators
// that are synchronous to mclk_i except the two host pins, which are synchronised here.
// Analog loops and the serial slave sit outside.
//
// Behaviour
// - Voltage-source mode in precharge/termination, current in fast charge, else off.
// - Precharge current programmable, capped at 500mA.
// - Per-zone three-bit fast current modifier.
// - Precharge threshold from its config register.
// - No charge done while input limit active.
// - Done must hold 140us before declaring.
// - Thermal zones apply only when enabled.
// - Outside all zones, charger off when monitoring.
// - Pull-up field enables thermistor switch.
// - Per-zone charge disable and voltage reduction.
// - SDP and low battery: 500mA, 2min, zero.
// - Clearing weak enable stops sequence, host control.
// - Thermistor pulled high clears battery present.
// - Data switch manual or automatic on SDP/CDP.
// - Aux regulator auto or manual, level selectable.
// - Host pins honoured only with input supply.
// - Suspend opens switch, zero limit, unless masked.
// - Fault input places charger in fault.
// - Orientation low when CC1 active, else released.
// - System OK asserted while rail above threshold.
// - Rail undervoltage opens input protection switch.
// - Connector supply enable when powered device found.
// - Fault input active low, high releases.
// - Latched faults persist until charge enable cycled.
`timescale 1ns/1ps
`include "bcc_defines.svh"
module bcc_charger_control
  import bcc_pkg::*;
#(
  // Countdown length; wider than 32 bits.
  parameter longint unsigned WEAK_CYCLES = `BCC_WEAK_CYC
) (
  input wire logic mclk_i,
  input wire logic rst_i,

  // Register port.
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_valid_o,

  // Supply, host pins and comparators.
  input wire logic input_supply_i,
  input wire logic force_suspend_in_i,
  input wire logic fault_in_n_i,
  input wire logic thermistor_sense_high_i,
  input wire logic [1:0] temp_zone_i,
  input wire logic temp_in_zone_i,
  input wire logic bat_below_precharge_i,
  input wire logic done_current_i,
  input wire logic ilim_active_i,
  input wire logic timer_expired_i,
  input wire logic sys_above_uv_i,
  input wire logic sdp_detected_i,
  input wire logic cdp_detected_i,
  input wire logic cc1_active_i,
  input wire logic vconn_needed_i,

  // Charger phase and converter.
  output logic [2:0] phase_o,
  output logic [1:0] conv_mode_o,
  output logic [2:0] precharge_current_o,
  output logic [2:0] fast_current_mod_o,
  output logic [7:0] precharge_threshold_o,
  output logic voltage_reduce_o,
  output logic charge_done_o,
  output logic thermistor_pullup_o,

  // Input path and switches.
  output logic [7:0] input_ilim_o,
  output logic ilim_override_o,
  output logic input_switch_open_o,
  output logic data_switch_on_o,
  output logic aux_regulator_out_o,
  output logic aux_regulator_level_o,

  // Open-drain pins as level and enable.
  output logic orientation_out_o,
  output logic orientation_out_oe_o,
  output logic system_ok_out_o,
  output logic system_ok_out_oe_o,
  output logic conn_supply_enable_o
);

  // ===========================================================================
  // Registers
  // ===========================================================================
  // Host-written configuration.
  logic [7:0] thermal_config_1;
  logic [7:0] thermal_config_2;
  logic [7:0] thermal_config_3;
  logic [7:0] charger_control_1;
  logic [7:0] precharge_threshold_config;
  logic [7:0] data_switch_control;
  logic [7:0] fault_input_config;
  logic [7:0] weak_control;

  // Pin synchroniser stages.
  logic susp_s1;
  logic susp_s2;
  logic flt_s1;
  logic flt_s2;

  // Sequencer state and counters.
  bcc_phase_e phase;
  bcc_weak_e weak_state;
  logic [13:0] deb_cnt;
  logic [33:0] weak_cnt;
  logic done_flag;
  logic chg_en_d;
  logic fault_latched;

  // Register writes from the serial slave.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      thermal_config_1 <= `BCC_RST_THERM;
      thermal_config_2 <= `BCC_RST_THERM;
      thermal_config_3 <= `BCC_RST_THERM;
      charger_control_1 <= `BCC_RST_CHGCTL;
      precharge_threshold_config <= `BCC_RST_PRETHR;
      data_switch_control <= `BCC_RST_DSWCTL;
      fault_input_config <= `BCC_RST_FLTCFG;
      weak_control <= `BCC_RST_WEAKCTL;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `BCC_OFS_THERM1: thermal_config_1 <= reg_wdata_i;
        `BCC_OFS_THERM2: thermal_config_2 <= reg_wdata_i;
        `BCC_OFS_THERM3: thermal_config_3 <= reg_wdata_i;
        `BCC_OFS_CHGCTL: charger_control_1 <= reg_wdata_i;
        `BCC_OFS_PRETHR: precharge_threshold_config <= reg_wdata_i;
        `BCC_OFS_DSWCTL: data_switch_control <= reg_wdata_i;
        `BCC_OFS_FLTCFG: fault_input_config <= reg_wdata_i;
        `BCC_OFS_WEAKCTL: weak_control <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  // Control bits decoded from the registers.
  wire charge_enable = charger_control_1[`BCC_CC_EN_BIT];
  wire [2:0] pcur_code = charger_control_1[`BCC_CC_PCUR_LSB +: 3];
  wire thermal_control_enable = thermal_config_3[`BCC_TC3_EN_BIT];
  wire [1:0] thermistor_pullup_config = thermal_config_3[`BCC_TC3_PU_LSB +: 2];

  // Switch and regulator modes.
  wire [1:0] data_switch_mode = data_switch_control[1:0];
  wire [1:0] aux_mode = data_switch_control[`BCC_DS_AUXM_LSB +: 2];
  wire aux_regulator_level = data_switch_control[`BCC_DS_LVL_BIT];

  // Pin and countdown enables.
  wire fault_in_enable = fault_input_config[`BCC_FC_EN_BIT];
  wire suspend_mask = fault_input_config[`BCC_FC_SMASK_BIT];
  wire weak_battery_enable = weak_control[`BCC_WB_EN_BIT];

  // ===========================================================================
  // Pin synchronisers
  // ===========================================================================
  // Two stages for the asynchronous host pins; only stage two is used.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      susp_s1 <= 1'b0;
      susp_s2 <= 1'b0;
      flt_s1 <= 1'b1;
      flt_s2 <= 1'b1;
    end else begin
      susp_s1 <= force_suspend_in_i;
      susp_s2 <= susp_s1;
      flt_s1 <= fault_in_n_i;
      flt_s2 <= flt_s1;
    end
  end

  // Pin effects gated by input supply presence.
  wire suspend_active = input_supply_i && susp_s2 && !suspend_mask;
  wire forced_fault = input_supply_i && fault_in_enable && !flt_s2;

  // ===========================================================================
  // Thermal zones
  // ===========================================================================
  // Zone 0 is the cold zone, 1 the middle zone, 2 the hot zone.
  wire zone_cold = (temp_zone_i == 2'd0);
  wire zone_hot = (temp_zone_i == 2'd2);
  wire [7:0] zone_cfg = zone_hot ? thermal_config_2 : thermal_config_1;
  wire zone_charge_enable = zone_cfg[`BCC_TC_ZEN_BIT];
  wire zone_voltage_reduce = zone_cfg[`BCC_TC_VRED_BIT];
  wire [2:0] zone_fast_current_mod = zone_cfg[`BCC_TC_MOD_LSB +: 3];

  // Cold or hot zone may forbid charging.
  wire zone_block = (zone_cold || zone_hot) && !zone_charge_enable;
  wire thermal_off = thermal_control_enable && (!temp_in_zone_i || zone_block);

  // ===========================================================================
  // Charge phase sequencing
  // ===========================================================================
  // Release edge and qualifiers.
  wire chg_en_fall = chg_en_d && !charge_enable;
  wire done_raw = done_current_i && !ilim_active_i;
  wire allow = charge_enable && !thermal_off && !suspend_active && !forced_fault;

  // Next phase.
  bcc_phase_e next_phase;

  // Next phase; latched faults leave only on a charge enable cycle.
  always_comb begin
    next_phase = phase;
    case (phase)
      BCC_IDLE: if (allow) next_phase = BCC_PRE;
      BCC_PRE: begin
        if (!allow) next_phase = BCC_IDLE;
        else if (!bat_below_precharge_i) next_phase = BCC_FAST;
      end
      BCC_FAST: if (!allow) next_phase = BCC_IDLE;
        else if (done_current_i) next_phase = BCC_TERM;
      BCC_TERM: if (!allow) next_phase = BCC_IDLE;
        else if (done_flag) next_phase = BCC_DONE;
      BCC_DONE: if (!allow) next_phase = BCC_IDLE;
      default: next_phase = BCC_FAULT;
    endcase
    // Faults override every phase.
    if (fault_latched || forced_fault) next_phase = BCC_FAULT;
    else if (phase == BCC_FAULT) next_phase = BCC_IDLE;
  end

  // Phase register and latched fault.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      phase <= BCC_IDLE;
      chg_en_d <= 1'b0;
      fault_latched <= 1'b0;
    end else begin
      phase <= next_phase;
      chg_en_d <= charge_enable;
      if (timer_expired_i && phase != BCC_IDLE) fault_latched <= 1'b1;
      else if (chg_en_fall) fault_latched <= 1'b0;
    end
  end

  // Done debounce.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      deb_cnt <= 14'h0000;
      done_flag <= 1'b0;
    end else if (!done_raw || phase != BCC_TERM) begin
      deb_cnt <= 14'h0000;
      done_flag <= 1'b0;
    end else if (deb_cnt == 14'(`BCC_DONE_DEB_CYC - 1)) begin
      done_flag <= 1'b1;
    end else begin
      deb_cnt <= deb_cnt + 14'h0001;
    end
  end

  // ===========================================================================
  // Weak battery timer
  // ===========================================================================
  // Countdown start.
  wire weak_start = sdp_detected_i && bat_below_precharge_i;

  // Weak battery countdown.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      weak_state <= BCC_WB_IDLE;
      weak_cnt <= 34'h0;
    end else if (!weak_battery_enable || !input_supply_i) begin
      weak_state <= BCC_WB_IDLE;
      weak_cnt <= 34'h0;
    end else begin
      case (weak_state)
        BCC_WB_IDLE: if (weak_start) weak_state <= BCC_WB_RUN;
        BCC_WB_RUN: begin
          if (weak_cnt == 34'(WEAK_CYCLES - 1)) weak_state <= BCC_WB_EXPIRED;
          else weak_cnt <= weak_cnt + 34'h1;
        end
        BCC_WB_EXPIRED: ;
        default: weak_state <= BCC_WB_IDLE;
      endcase
    end
  end

  // ===========================================================================
  // Output stage
  // ===========================================================================
  // Converter and switch decode.
  wire pre_like = (phase == BCC_PRE) || (phase == BCC_TERM);
  wire [2:0] pcur = (pcur_code > `BCC_PCUR_MAX) ? `BCC_PCUR_MAX : pcur_code;
  wire port_ok = sdp_detected_i || cdp_detected_i;
  wire dsw_on = (data_switch_mode == 2'b01) ||
                ((data_switch_mode == 2'b10) && port_ok);
  wire aux_on = input_supply_i && ((aux_mode == 2'b01) ||
                ((aux_mode == 2'b10) && port_ok));

  // Forced zero input limit.
  wire zero_ilim = suspend_active || (weak_state == BCC_WB_EXPIRED);

  // Register read mux.
  wire [7:0] rd_mux =
    (reg_addr_i == `BCC_OFS_THERM1) ? thermal_config_1 :
    (reg_addr_i == `BCC_OFS_THERM2) ? thermal_config_2 :
    (reg_addr_i == `BCC_OFS_THERM3) ? thermal_config_3 :
    (reg_addr_i == `BCC_OFS_CHGCTL) ? charger_control_1 :
    (reg_addr_i == `BCC_OFS_PRETHR) ? precharge_threshold_config :
    (reg_addr_i == `BCC_OFS_DSWCTL) ? data_switch_control :
    (reg_addr_i == `BCC_OFS_FLTCFG) ? fault_input_config :
    (reg_addr_i == `BCC_OFS_WEAKCTL) ? weak_control :
    (reg_addr_i == `BCC_OFS_STATUS) ?
      {cc1_active_i, fault_latched, done_flag, !thermistor_sense_high_i, 1'b0, phase} : 8'h00;

  // Mapped address flag.
  wire rd_valid = (rd_mux != 8'h00) || (reg_addr_i == `BCC_OFS_THERM1) ||
                  (reg_addr_i == `BCC_OFS_THERM2) || (reg_addr_i == `BCC_OFS_THERM3) ||
                  (reg_addr_i == `BCC_OFS_CHGCTL) || (reg_addr_i == `BCC_OFS_PRETHR) ||
                  (reg_addr_i == `BCC_OFS_DSWCTL) || (reg_addr_i == `BCC_OFS_FLTCFG) ||
                  (reg_addr_i == `BCC_OFS_WEAKCTL) || (reg_addr_i == `BCC_OFS_STATUS);

  // All outputs registered.
  // Open-drain levels stay low.
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
      reg_valid_o <= 1'b0;
      phase_o <= 3'h0;
      conv_mode_o <= 2'h0;
      precharge_current_o <= 3'h0;
      fast_current_mod_o <= 3'h0;
      precharge_threshold_o <= 8'h00;
      voltage_reduce_o <= 1'b0;
      charge_done_o <= 1'b0;
      thermistor_pullup_o <= 1'b0;
      input_ilim_o <= 8'h00;
      ilim_override_o <= 1'b0;
      input_switch_open_o <= 1'b1;
      data_switch_on_o <= 1'b0;
      aux_regulator_out_o <= 1'b0;
      aux_regulator_level_o <= 1'b0;
      orientation_out_o <= 1'b0;
      orientation_out_oe_o <= 1'b0;
      system_ok_out_o <= 1'b0;
      system_ok_out_oe_o <= 1'b0;
      conn_supply_enable_o <= 1'b0;
    end else begin
      reg_rdata_o <= rd_mux;
      reg_valid_o <= rd_valid;
      phase_o <= phase;
      conv_mode_o <= pre_like ? BCC_CONV_VSRC :
                     (phase == BCC_FAST) ? BCC_CONV_ISRC : BCC_CONV_OFF;
      precharge_current_o <= pcur;
      fast_current_mod_o <= thermal_control_enable ? zone_fast_current_mod : 3'h0;
      precharge_threshold_o <= precharge_threshold_config;
      voltage_reduce_o <= thermal_control_enable && zone_voltage_reduce;
      charge_done_o <= (phase == BCC_DONE);
      thermistor_pullup_o <= (phase != BCC_IDLE) || (thermistor_pullup_config != 2'b00);
      input_ilim_o <= zero_ilim ? `BCC_ILIM_ZERO : `BCC_ILIM_500MA;
      ilim_override_o <= zero_ilim || (weak_state == BCC_WB_RUN);
      input_switch_open_o <= suspend_active || !sys_above_uv_i;
      data_switch_on_o <= dsw_on;
      aux_regulator_out_o <= aux_on;
      aux_regulator_level_o <= aux_regulator_level;

      // Supply-gated pin enables.
      orientation_out_oe_o <= input_supply_i && cc1_active_i;
      system_ok_out_oe_o <= input_supply_i && sys_above_uv_i;
      conn_supply_enable_o <= input_supply_i && vconn_needed_i;
    end
  end

endmodule

//--- hdl/bcc_defines.svh
// Register offsets, field positions, reset values and timing counts of the charger control.
// Assumes inclusion by bare name from the design file.
`ifndef BCC_DEFINES_SVH
`define BCC_DEFINES_SVH
`define BCC_OFS_THERM1 8'h1a
`define BCC_OFS_THERM2 8'h1b
`define BCC_OFS_THERM3 8'h1c
`define BCC_OFS_CHGCTL 8'h1d
`define BCC_OFS_PRETHR 8'h1e
`define BCC_OFS_DSWCTL 8'h2f
`define BCC_OFS_FLTCFG 8'h35
`define BCC_OFS_STATUS 8'h40
`define BCC_OFS_WEAKCTL 8'h41
// Thermal config 1/2: [2:0] zone current modifier, [3] zone charge enable, [4] voltage reduce.
`define BCC_TC_MOD_LSB 0
`define BCC_TC_ZEN_BIT 3
`define BCC_TC_VRED_BIT 4
// Thermal config 3: [0] control enable, [2:1] pull-up config.
`define BCC_TC3_EN_BIT 0
`define BCC_TC3_PU_LSB 1
// Charger control 1: [0] charge enable, [3:1] precharge current code.
`define BCC_CC_EN_BIT 0
`define BCC_CC_PCUR_LSB 1
// Data switch: [1:0] switch mode, [3:2] aux mode, [4] aux level.
`define BCC_DS_AUXM_LSB 2
`define BCC_DS_LVL_BIT 4
// Fault input config: [0] fault input enable, [1] suspend mask.
`define BCC_FC_EN_BIT 0
`define BCC_FC_SMASK_BIT 1
// Weak battery control: [0] weak battery enable.
`define BCC_WB_EN_BIT 0
`define BCC_RST_THERM 8'h00
`define BCC_RST_CHGCTL 8'h00
`define BCC_RST_PRETHR 8'h00
`define BCC_RST_DSWCTL 8'h00
`define BCC_RST_FLTCFG 8'h01
`define BCC_RST_WEAKCTL 8'h01
`define BCC_CLK_MHZ 100
`define BCC_DONE_DEB_US 140
`define BCC_DONE_DEB_CYC (`BCC_DONE_DEB_US * `BCC_CLK_MHZ)
`define BCC_WEAK_MIN 2
`define BCC_WEAK_CYC (`BCC_WEAK_MIN * 64'd60 * 64'd1000000 * `BCC_CLK_MHZ)
`define BCC_ILIM_500MA 8'h04
`define BCC_ILIM_ZERO 8'h00
`define BCC_PCUR_MAX 3'h7
`endif

//--- hdl/bcc_pkg.sv
// Types shared by the charger control logic.
// Assumes the defines header is available on the include path.
package bcc_pkg;
  typedef enum logic [2:0] {
    BCC_IDLE = 3'b000,
    BCC_PRE = 3'b001,
    BCC_FAST = 3'b010,
    BCC_TERM = 3'b011,
    BCC_DONE = 3'b100,
    BCC_FAULT = 3'b101
  } bcc_phase_e;
  typedef enum logic [1:0] {
    BCC_CONV_OFF = 2'b00,
    BCC_CONV_VSRC = 2'b01,
    BCC_CONV_ISRC = 2'b10
  } bcc_conv_e;
  typedef enum logic [1:0] {
    BCC_WB_IDLE = 2'b00,
    BCC_WB_RUN = 2'b01,
    BCC_WB_EXPIRED = 2'b10
  } bcc_weak_e;
endpackage
